// [hw/clock_power_pkg.sv]
// Constants, field layouts and types of the keyed power and clock control
package clock_power_pkg;

  // ************************************************************
  // Register map and keys
  // ************************************************************
  localparam logic [31:0] ADDR_POWER_KEY_A   = 32'hffff0404;
  localparam logic [31:0] ADDR_POWER_MODE    = 32'hffff0408;
  localparam logic [31:0] ADDR_POWER_KEY_B   = 32'hffff040c;
  localparam logic [31:0] ADDR_PLL_KEY_A     = 32'hffff0410;
  localparam logic [31:0] ADDR_PLL_SOURCE    = 32'hffff0414;
  localparam logic [31:0] ADDR_PLL_KEY_B     = 32'hffff0418;
  localparam logic [31:0] ADDR_POWER_KEY_C   = 32'hffff0434;
  localparam logic [31:0] ADDR_CLOCK_GATE    = 32'hffff0438;
  localparam logic [31:0] ADDR_POWER_KEY_D   = 32'hffff043c;

  localparam logic [15:0] KEY_POWER_A        = 16'h0001;
  localparam logic [15:0] KEY_POWER_B        = 16'h00f4;
  localparam logic [15:0] KEY_PLL_A          = 16'h00aa;
  localparam logic [15:0] KEY_PLL_B          = 16'h0055;

  // ************************************************************
  // Fields and reset values
  // ************************************************************
  localparam logic [6:0]  MODE_RESET         = 7'h7b;
  localparam logic [3:0]  MODE_ACTIVE        = 4'hf;
  localparam logic [15:0] GATE_RESET         = 16'h0124;
  localparam logic [15:0] GATE_MASK          = 16'h0124;
  localparam int          GATE_PWM_BIT       = 8;
  localparam int          GATE_UART_BIT      = 5;
  localparam int          GATE_SPI_BIT       = 2;
  localparam logic [7:0]  PLL_RESET          = 8'h00;
  localparam logic [7:0]  PLL_MASK           = 8'h07;
  localparam int          PLL_EXT_BIT        = 2;
  localparam logic [1:0]  OSCILLATOR_SELECT_CRYSTAL       = 2'h2;
  localparam logic [2:0]  DIV_FASTEST        = 3'h0;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int unsigned CLK_PERIOD_NS      = 5;
  localparam int unsigned T_STARTUP_NS       = 130_000_000;
  localparam int unsigned T_WAKE_SHORT_0_NS  = 4_800;
  localparam int unsigned T_WAKE_SHORT_7_NS  = 660_000;
  localparam int unsigned T_WAKE_LONG_0_NS   = 66_000;
  localparam int unsigned T_WAKE_LONG_7_NS   = 900_000;
  localparam int unsigned CYC_STARTUP        = T_STARTUP_NS / CLK_PERIOD_NS;
  localparam int unsigned CYC_WAKE_SHORT_0   =
    T_WAKE_SHORT_0_NS / CLK_PERIOD_NS;
  localparam int unsigned CYC_WAKE_SHORT_7   =
    T_WAKE_SHORT_7_NS / CLK_PERIOD_NS;
  localparam int unsigned CYC_WAKE_LONG_0    = T_WAKE_LONG_0_NS / CLK_PERIOD_NS;
  localparam int unsigned CYC_WAKE_LONG_7    = T_WAKE_LONG_7_NS / CLK_PERIOD_NS;
  localparam int          CNT_W              = 28;
  localparam int          NUM_KEYS           = 3;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic       crystal_enable;
    logic       pll_enable;
    logic       peripheral_enable;
    logic       core_enable;
    logic [2:0] core_clock_divider;
  } power_mode_type;

  typedef enum logic [3:0] {
    ST_STARTUP = 4'h1,
    ST_RUN     = 4'h2,
    ST_LOW     = 4'h4,
    ST_WAKE    = 4'h8
  } power_state_type;

endpackage

// [hw/key_window.sv]
// One-write window opened by a correct key write
module key_window (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic wr_stb,
  input  wire logic key_hit,
  input  wire logic prev_ok,
  output logic      armed
);

  logic armed_ff;
  wire  nxt_armed = key_hit & prev_ok;

  // Any write closes or reopens the window; reads never touch it
  always_ff @(posedge mclk) begin
    if (rst) begin
      armed_ff <= 1'b0;
    end else if (ce && wr_stb) begin
      armed_ff <= nxt_armed;
    end
  end

  assign armed = armed_ff;

endmodule

// [hw/wake_timer.sv]
// Down counter for start-up and wake-up latency
module wake_timer import clock_power_pkg::*; #(
  parameter logic [CNT_W-1:0] RESET_CYCLES = '0
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             ce,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_cycles,
  output logic                  done
);

  logic [CNT_W-1:0] count_ff;
  wire  [CNT_W-1:0] nxt_count = load ? load_cycles :
                                (count_ff != '0) ? count_ff - 1'b1 : count_ff;

  always_ff @(posedge mclk) begin
    if (rst) begin
      count_ff <= RESET_CYCLES;
    end else if (ce) begin
      count_ff <= nxt_count;
    end
  end

  assign done = (count_ff == '0);

endmodule

// [hw/keyed_power_clock_control.sv]
// Keyed power mode and PLL source control, with an unkeyed peripheral clock gate
//
// The strobed register port is this design's own decision.
module keyed_power_clock_control import clock_power_pkg::*; #(
  parameter int unsigned STARTUP_CYCLES      = CYC_STARTUP,
  parameter int unsigned WAKE_SHORT_7_CYCLES = CYC_WAKE_SHORT_7,
  parameter int unsigned WAKE_LONG_0_CYCLES  = CYC_WAKE_LONG_0,
  parameter int unsigned WAKE_LONG_7_CYCLES  = CYC_WAKE_LONG_7
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [31:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic [3:0]  irq_in,
  output logic      [3:0]  irq_out,
  output logic             pwm_clock_enable,
  output logic             serial_port_clock_enable,
  output logic             two_wire_spi_clock_enable,
  output logic             crystal_enable,
  output logic             pll_enable,
  output logic             peripheral_enable,
  output logic             core_enable,
  output logic      [2:0]  core_clock_divider,
  output logic             ext_clock_select,
  output logic             crystal_select
);

  // ************************************************************
  // Address decode
  // ************************************************************
  wire hit_mode  = (reg_addr == ADDR_POWER_MODE);
  wire hit_gate  = (reg_addr == ADDR_CLOCK_GATE);
  wire hit_pll   = (reg_addr == ADDR_PLL_SOURCE);
  wire hit_pllkb = (reg_addr == ADDR_PLL_KEY_B);
  wire hit_key   = (reg_addr == ADDR_POWER_KEY_A) ||
                   (reg_addr == ADDR_POWER_KEY_B) ||
                   (reg_addr == ADDR_POWER_KEY_C) ||
                   (reg_addr == ADDR_POWER_KEY_D) ||
                   (reg_addr == ADDR_PLL_KEY_A)   || hit_pllkb;
  wire wr_en     = ce & reg_wr;

  // ************************************************************
  // Key windows
  // ************************************************************
  localparam logic [31:0] KEY_ADDR [NUM_KEYS] =
    '{ADDR_POWER_KEY_A, ADDR_POWER_KEY_B, ADDR_PLL_KEY_A};
  localparam logic [15:0] KEY_VAL [NUM_KEYS] =
    '{KEY_POWER_A, KEY_POWER_B, KEY_PLL_A};

  logic [NUM_KEYS-1:0] armed;

  genvar k;
  generate
    for (k = 0; k < NUM_KEYS; k++) begin : g_key
      // Power key b only counts right after power key a
      wire prev_ok = (k == 1) ? armed[0] : 1'b1;
      key_window u_key (
        .mclk    (mclk),
        .rst     (rst),
        .ce      (ce),
        .wr_stb  (reg_wr),
        .key_hit ((reg_addr == KEY_ADDR[k]) && (reg_wdata == KEY_VAL[k])),
        .prev_ok (prev_ok),
        .armed   (armed[k])
      );
    end
  endgenerate

  logic pll_pend_ff;

  wire mode_ok   = wr_en & hit_mode & armed[1];
  wire pll_stage = wr_en & hit_pll & armed[2];
  wire pll_ok    = wr_en & hit_pllkb & pll_pend_ff &
                   (reg_wdata == KEY_PLL_B);

  // ************************************************************
  // Registers
  // ************************************************************
  power_mode_type  mode_ff;
  power_mode_type  nxt_mode;
  logic [15:0]     gate_ff;
  logic [7:0]      pll_ff;
  logic [7:0]      pll_data_ff;
  logic [15:0]     rdata_ff;
  logic [3:0]      irq_ff;
  logic            core_run_ff;
  power_state_type state_ff;
  power_state_type nxt_state;

  wire in_low    = (state_ff == ST_LOW);
  wire wake_evt  = in_low & (|irq_in);
  wire low_req   = ~mode_ff.core_enable;

  // Wake bits win over a concurrent mode write
  always_comb begin
    nxt_mode = mode_ff;
    if (mode_ok) begin
      nxt_mode = power_mode_type'(reg_wdata[6:0]);
    end
    if (wake_evt) begin
      nxt_mode.pll_enable        = 1'b1;
      nxt_mode.peripheral_enable = 1'b1;
      nxt_mode.core_enable       = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_ff <= power_mode_type'(MODE_RESET);
      gate_ff <= GATE_RESET;
      pll_ff  <= PLL_RESET;
    end else if (ce) begin
      mode_ff <= nxt_mode;
      if (reg_wr && hit_gate) begin
        gate_ff <= reg_wdata & GATE_MASK;
      end
      if (pll_ok) begin
        pll_ff <= pll_data_ff;
      end
    end
  end

  // Staged PLL value dies on any other write
  always_ff @(posedge mclk) begin
    if (rst) begin
      pll_pend_ff <= 1'b0;
      pll_data_ff <= PLL_RESET;
    end else if (wr_en) begin
      pll_pend_ff <= pll_stage;
      if (pll_stage) begin
        pll_data_ff <= reg_wdata[7:0] & PLL_MASK;
      end
    end
  end

  // ************************************************************
  // Power state and wake latency
  // ************************************************************
  // Divider codes 1 to 6 take the slow figure: safe upper bound
  wire long_wake = ~mode_ff.pll_enable;
  wire fast_div  = (mode_ff.core_clock_divider == DIV_FASTEST);
  wire [CNT_W-1:0] wake_cycles =
    long_wake ? (fast_div ? CNT_W'(WAKE_LONG_0_CYCLES)
                          : CNT_W'(WAKE_LONG_7_CYCLES))
              : (fast_div ? CNT_W'(CYC_WAKE_SHORT_0)
                          : CNT_W'(WAKE_SHORT_7_CYCLES));
  logic timer_done;

  wake_timer #(
    .RESET_CYCLES (CNT_W'(STARTUP_CYCLES))
  ) u_timer (
    .mclk        (mclk),
    .rst         (rst),
    .ce          (ce),
    .load        (wake_evt),
    .load_cycles (wake_cycles),
    .done        (timer_done)
  );

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_STARTUP: if (timer_done) nxt_state = ST_RUN;
      ST_RUN:     if (low_req) nxt_state = ST_LOW;
      ST_LOW:     if (wake_evt) nxt_state = ST_WAKE;
      ST_WAKE:    if (timer_done) nxt_state = ST_RUN;
      default:    nxt_state = ST_STARTUP;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff    <= ST_STARTUP;
      core_run_ff <= 1'b0;
      irq_ff      <= 4'h0;
    end else if (ce) begin
      state_ff    <= nxt_state;
      core_run_ff <= (nxt_state == ST_RUN) & nxt_mode.core_enable;
      irq_ff      <= irq_in;
    end
  end

  // ************************************************************
  // Read port
  // ************************************************************
  wire [15:0] rd_value =
    hit_mode ? {9'h000, mode_ff} :
    hit_gate ? gate_ff :
    hit_pll  ? {8'h00, pll_ff} : 16'h0000;

  always_ff @(posedge mclk) begin
    if (rst) begin
      rdata_ff <= 16'h0000;
    end else if (ce) begin
      rdata_ff <= reg_rd ? rd_value : 16'h0000;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign reg_rdata                 = rdata_ff;
  assign irq_out                   = irq_ff;
  assign pwm_clock_enable          = gate_ff[GATE_PWM_BIT];
  assign serial_port_clock_enable  = gate_ff[GATE_UART_BIT];
  assign two_wire_spi_clock_enable = gate_ff[GATE_SPI_BIT];
  assign crystal_enable            = mode_ff.crystal_enable;
  assign pll_enable                = mode_ff.pll_enable;
  assign peripheral_enable         = mode_ff.peripheral_enable;
  assign core_enable               = core_run_ff;
  assign core_clock_divider        = mode_ff.core_clock_divider;
  assign ext_clock_select          = pll_ff[PLL_EXT_BIT];
  assign crystal_select            = (pll_ff[1:0] == OSCILLATOR_SELECT_CRYSTAL);

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  gate_reset_a: assert property ($past(rst) |-> gate_ff == GATE_RESET)
    else $error("clock gate reset value wrong");
  pwm_gate_a: assert property (wr_en && hit_gate |=>
    pwm_clock_enable == $past(reg_wdata[GATE_PWM_BIT]))
    else $error("pwm enable not taken from write");
  uart_gate_a: assert property (wr_en && hit_gate |=>
    serial_port_clock_enable == $past(reg_wdata[GATE_UART_BIT]))
    else $error("uart enable not taken from write");
  spi_gate_a: assert property (wr_en && hit_gate |=>
    two_wire_spi_clock_enable == $past(reg_wdata[GATE_SPI_BIT]))
    else $error("two-wire enable not taken from write");
  mode_guard_a: assert property (wr_en && hit_mode && !armed[1] |=>
    core_clock_divider == $past(core_clock_divider))
    else $error("unkeyed mode write took effect");
  mode_commit_a: assert property (
    reg_wr && reg_addr == ADDR_POWER_KEY_A && reg_wdata == KEY_POWER_A
    && ce ##1 reg_wr && reg_addr == ADDR_POWER_KEY_B
    && reg_wdata == KEY_POWER_B && ce ##1 wr_en && hit_mode
    |=> core_clock_divider == $past(reg_wdata[2:0]))
    else $error("keyed mode write lost");
  pll_hold_a: assert property (wr_en && hit_pll |=>
    pll_ff == $past(pll_ff))
    else $error("pll source changed before closing key");
  pll_commit_a: assert property (
    wr_en && hit_pll && armed[2] ##1 wr_en && hit_pllkb
    && reg_wdata == KEY_PLL_B
    |=> pll_ff == ($past(reg_wdata, 2) & 16'h0007))
    else $error("keyed pll write lost");
  key_read_a: assert property (ce && reg_rd && hit_key |=>
    reg_rdata == 16'h0000 && $stable(armed))
    else $error("key register read not zero");
  wake_bits_a: assert property (ce && wake_evt |=>
    pll_enable && peripheral_enable && state_ff == ST_WAKE)
    else $error("wake did not restore enables");
  irq_pass_a: assert property (ce |=> irq_out == $past(irq_in))
    else $error("interrupt not passed");
  mode_reset_a: assert property ($past(rst) |->
    mode_ff == power_mode_type'(MODE_RESET))
    else $error("mode reset value wrong");
  pll_reset_a: assert property ($past(rst) |-> pll_ff == PLL_RESET)
    else $error("pll source reset value wrong");
  pll_refuse_a: assert property (
    wr_en && hit_pllkb && !pll_pend_ff |=> pll_ff == $past(pll_ff))
    else $error("unstaged pll source write took effect");
  ext_clock_a: assert property (pll_ok |=>
    ext_clock_select == $past(pll_data_ff[PLL_EXT_BIT]))
    else $error("external clock select not taken");
  crystal_sel_a: assert property (pll_ok |=>
    crystal_select == ($past(pll_data_ff[1:0]) == OSCILLATOR_SELECT_CRYSTAL))
    else $error("oscillator decode wrong");
  low_entry_a: assert property (
    ce && state_ff == ST_RUN && !mode_ff.core_enable |=>
    state_ff == ST_LOW && !core_enable)
    else $error("core kept running in low power mode");
  stay_low_a: assert property (
    ce && in_low && irq_in == 4'h0 |=> in_low)
    else $error("left low power without an interrupt");
  // Even the shortest wake keeps the core off for a while
  wake_wait_a: assert property (
    ce && wake_evt |=> !core_enable [*2])
    else $error("core ran before wake latency");
  // Clock enable low must leave the gate, PLL source and mode registers as they were
  ce_freeze_a: assert property (!ce |=>
    gate_ff == $past(gate_ff) && pll_ff == $past(pll_ff)
    && mode_ff == $past(mode_ff))
    else $error("state moved while clock enable low");

endmodule

// [test/test_keyed_power_clock_control.sv]
// Self-checking bench for the keyed power and clock control block
module test_keyed_power_clock_control import clock_power_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;

  // ************************************************************
  // Signals and design instance
  // ************************************************************
  // Short counts keep the run small; 960 is fixed in the design
  localparam int SU  = 20;
  localparam int WS7 = 30;
  localparam int WL0 = 40;
  localparam int WL7 = 50;

  logic        mclk;
  logic        rst;
  logic        ce;
  logic [31:0] reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic [3:0]  irq_in;
  logic [3:0]  irq_out;
  logic        pwm_clock_enable;
  logic        serial_port_clock_enable;
  logic        two_wire_spi_clock_enable;
  logic        crystal_enable;
  logic        pll_enable;
  logic        peripheral_enable;
  logic        core_enable;
  logic [2:0]  core_clock_divider;
  logic        ext_clock_select;
  logic        crystal_select;
  int          n_errors;
  int          n_tests;

  keyed_power_clock_control #(
    .STARTUP_CYCLES(SU), .WAKE_SHORT_7_CYCLES(WS7),
    .WAKE_LONG_0_CYCLES(WL0), .WAKE_LONG_7_CYCLES(WL7)
  ) i_dut (
    .mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_in(irq_in), .irq_out(irq_out),
    .pwm_clock_enable(pwm_clock_enable),
    .serial_port_clock_enable(serial_port_clock_enable),
    .two_wire_spi_clock_enable(two_wire_spi_clock_enable),
    .crystal_enable(crystal_enable), .pll_enable(pll_enable),
    .peripheral_enable(peripheral_enable), .core_enable(core_enable),
    .core_clock_divider(core_clock_divider),
    .ext_clock_select(ext_clock_select), .crystal_select(crystal_select)
  );

  always #2.5 mclk = ~mclk;

  // ************************************************************
  // Bus, compare and wait tasks
  // ************************************************************
  task automatic test_done();
    if (n_errors == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Every call drives all strobes once, so back-to-back cycles stay clean
  task automatic bus(input logic w, input logic r, input logic [31:0] a,
                     input logic [15:0] d);
    reg_wr    <= w;
    reg_rd    <= r;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask

  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 32'h0, 16'h0);
    #1;
  endtask

  task automatic rd_chk(input string what, input logic [31:0] a,
                        input logic [15:0] exp);
    bus(1'b0, 1'b1, a, 16'h0);
    #1;
    chk(what, exp, reg_rdata);
  endtask

  task automatic wait_core(output int n);
    n = 0;
    while (core_enable !== 1'b1) begin
      idle(1);
      n++;
      if (n > 2000) begin
        chk("core enable wait", 16'h1, {15'h0, core_enable});
        test_done();
      end
    end
  endtask

  function automatic logic [15:0] gate3();
    return {13'h0, pwm_clock_enable, serial_port_clock_enable,
            two_wire_spi_clock_enable};
  endfunction

  function automatic logic [15:0] pll2();
    return {14'h0, ext_clock_select, crystal_select};
  endfunction

  task automatic mode_write(input logic [15:0] d);
    wr(ADDR_POWER_KEY_A, KEY_POWER_A);
    rd_chk("key read", ADDR_POWER_KEY_B, 16'h0);
    wr(ADDR_POWER_KEY_B, KEY_POWER_B);
    wr(ADDR_POWER_MODE, d);
  endtask

  task automatic pll_write(input logic [15:0] d);
    wr(ADDR_PLL_KEY_A, KEY_PLL_A);
    wr(ADDR_PLL_SOURCE, d);
    wr(ADDR_PLL_KEY_B, KEY_PLL_B);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic startup_test();
    int n;
    wait_core(n);
    chk("startup window", 16'h1, {15'h0, n >= SU - 3 && n <= SU + 5});
    rd_chk("mode reset", ADDR_POWER_MODE, {9'h0, MODE_RESET});
    rd_chk("unmapped read", 32'hffff0500, 16'h0);
    idle(1);
    chk("rdata one cycle", 16'h0, reg_rdata);
  endtask

  task automatic gate_test();
    rd_chk("gate reset", ADDR_CLOCK_GATE, GATE_RESET);
    chk("enables reset", 16'h7, gate3());
    wr(ADDR_CLOCK_GATE, 16'h0000);
    idle(1);
    chk("all gated", 16'h0, gate3());
    wr(ADDR_CLOCK_GATE, 16'h0020);
    idle(1);
    chk("serial only", 16'h2, gate3());
    wr(ADDR_CLOCK_GATE, 16'h0004);
    idle(1);
    chk("spi only", 16'h1, gate3());
    wr(ADDR_CLOCK_GATE, 16'h0100);
    idle(1);
    chk("pwm only", 16'h4, gate3());
    wr(ADDR_CLOCK_GATE, 16'hffff);
    rd_chk("gate reserved", ADDR_CLOCK_GATE, GATE_MASK);
    ce <= 1'b0;
    wr(ADDR_CLOCK_GATE, 16'h0000);
    ce <= 1'b1;
    rd_chk("ce freeze", ADDR_CLOCK_GATE, GATE_MASK);
  endtask

  task automatic pll_test();
    int c;
    rd_chk("pll reset", ADDR_PLL_SOURCE, {8'h0, PLL_RESET});
    chk("pll outs reset", 16'h0, pll2());
    pll_write(16'h0006);
    idle(1);
    chk("ext and crystal", 16'h3, pll2());
    for (c = 0; c < 4; c++) begin
      pll_write(c[15:0]);
      idle(1);
      chk("oscillator_select decode", {15'h0, c == 2}, pll2());
    end
    pll_write(16'h00fd);
    rd_chk("pll reserved", ADDR_PLL_SOURCE, 16'h0005);
    wr(ADDR_PLL_KEY_A, KEY_PLL_A);
    wr(ADDR_PLL_SOURCE, 16'h0002);
    wr(ADDR_CLOCK_GATE, GATE_RESET);
    rd_chk("no trailing key", ADDR_PLL_SOURCE, 16'h0005);
    wr(ADDR_PLL_KEY_A, 16'h00ab);
    wr(ADDR_PLL_SOURCE, 16'h0002);
    wr(ADDR_PLL_KEY_B, KEY_PLL_B);
    rd_chk("wrong leading key", ADDR_PLL_SOURCE, 16'h0005);
  endtask

  task automatic mode_refused();
    wr(ADDR_POWER_KEY_B, KEY_POWER_B);
    wr(ADDR_POWER_MODE, 16'h0040);
    rd_chk("no first key", ADDR_POWER_MODE, {9'h0, MODE_RESET});
    wr(ADDR_POWER_KEY_A, KEY_POWER_A);
    wr(ADDR_POWER_KEY_B, 16'h00f5);
    wr(ADDR_POWER_MODE, 16'h0040);
    rd_chk("wrong key", ADDR_POWER_MODE, {9'h0, MODE_RESET});
    wr(ADDR_POWER_KEY_A, KEY_POWER_A);
    wr(ADDR_POWER_KEY_B, KEY_POWER_B);
    wr(ADDR_CLOCK_GATE, GATE_RESET);
    wr(ADDR_POWER_MODE, 16'h0040);
    idle(2);
    chk("core still on", 16'h1, {15'h0, core_enable});
    wr(ADDR_POWER_KEY_A, KEY_POWER_A);
    wr(ADDR_POWER_KEY_B, KEY_POWER_B);
    wr(ADDR_POWER_MODE, 16'h007a);
    rd_chk("direct keys", ADDR_POWER_MODE, 16'h007a);
  endtask

  // Each entry: mode and divider, then wake count by the latency table
  task automatic wake_test();
    logic [6:0] m [7] = '{7'h70, 7'h60, 7'h40, 7'h00, 7'h77, 7'h47, 7'h63};
    int         lat [7] = '{CYC_WAKE_SHORT_0, CYC_WAKE_SHORT_0,
                            WL0, WL0, WS7, WL7, WS7};
    int         i;
    int         n;
    for (i = 0; i < 7; i++) begin
      mode_write({9'h0, m[i]});
      idle(2);
      chk("mode outputs", {9'h0, m[i]}, {9'h0, crystal_enable, pll_enable,
          peripheral_enable, core_enable, core_clock_divider});
      irq_in <= 4'h1 << (i % 4);
      idle(1);
      chk("irq path", 16'h1 << (i % 4), {12'h0, irq_out});
      irq_in <= 4'h0;
      idle(1);
      chk("wake enables", 16'h3, {14'h0, pll_enable,
          peripheral_enable});
      wait_core(n);
      chk("wake latency", 16'h1,
          {15'h0, n + 2 >= lat[i] - 2 && n + 2 <= lat[i] + 4});
      rd_chk("mode after wake", ADDR_POWER_MODE,
             {9'h0, m[i] | 7'h38});
    end
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    n_errors  = 0;
    n_tests   = 0;
    mclk      = 1'b0;
    rst       = 1'b1;
    ce        = 1'b1;
    reg_addr  = 32'h0;
    reg_wdata = 16'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    irq_in    = 4'h0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    startup_test();
    gate_test();
    pll_test();
    mode_refused();
    wake_test();
    test_done();
  end
endmodule
